// ===== design/rts_sequencer.sv
// reset and time-out sequencer with reset-cause flags
// assumes all inputs synchronous to i_clock; i_srst is the power-on pulse
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module rts_sequencer #(
  parameter int PUD_TICKS = rts_pkg::PUD_RC_TICKS,
  parameter int OSC_STARTUP_EDGES = rts_pkg::OST_CYCLES,
  parameter int BROWNOUT_QUAL_CYC = rts_pkg::BROWNOUT_QUALIFY_CYC
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_supply_above_por,
  input wire logic i_supply_below_brownout,
  input wire logic i_rc_osc_clk,
  input wire logic i_osc_input_pin,
  input wire logic i_external_reset_pin_n,
  input wire logic i_power_up_delay_disable_cfg,
  input wire logic i_brownout_enable_cfg,
  input wire logic [2:0] i_clock_mode,
  input wire logic i_wdt_timeout,
  input wire logic i_wdt_clear,
  input wire logic i_sleep_cmd,
  input wire logic i_wake_irq,
  input wire logic i_global_irq_enable,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_chip_reset,
  output logic o_pud_active,
  output logic o_osc_startup_active,
  output logic o_pc_load,
  output logic [1:0] o_pc_sel,
  output logic [12:0] o_pc_vector,
  output logic o_timeout_flag,
  output logic o_power_down_flag
);

  typedef enum logic [2:0] {
    ST_POR_WAIT,
    ST_HOLD,
    ST_PUD,
    ST_OSC_START,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_START
  } rts_state_t;

  localparam int CW = rts_pkg::CNT_W;
  localparam int QW = rts_pkg::QUAL_W;
  localparam logic [CW-1:0] PUD_LAST = CW'(PUD_TICKS - 1);
  localparam logic [CW-1:0] OSC_LAST = CW'(OSC_STARTUP_EDGES - 1);
  localparam logic [QW-1:0] QUAL_LAST = QW'(BROWNOUT_QUAL_CYC);

  rts_state_t state;
  logic [CW-1:0] count;
  logic power_up;
  logic rc_prev;
  logic osc_prev;
  logic pin_low_prev;
  logic [QW-1:0] qual_count;
  logic brownout_trip;
  logic wake_to_irq;
  logic [2:0] status_high;
  logic [2:0] status_low;
  logic power_on_flag;
  logic brownout_flag;

  logic rc_edge;
  logic osc_edge;
  logic pin_low;
  logic pin_fall;
  logic brownout_active;
  logic brownout_event;
  logic crystal_mode;
  logic pud_enabled;
  logic wake_any;
  logic wake_finish;
  logic running;
  logic next_chip_reset;

  // ==========================================
  // input edges and qualifiers
  assign rc_edge = i_rc_osc_clk & ~rc_prev;
  assign osc_edge = i_osc_input_pin & ~osc_prev;
  assign pin_low = ~i_external_reset_pin_n;
  assign pin_fall = pin_low & ~pin_low_prev;
  assign brownout_active = i_brownout_enable_cfg & i_supply_below_brownout;
  assign pud_enabled = ~i_power_up_delay_disable_cfg;
  assign crystal_mode = (i_clock_mode == rts_pkg::MODE_CRYSTAL_LOW_POWER) |
                        (i_clock_mode == rts_pkg::MODE_CRYSTAL_MID) |
                        (i_clock_mode == rts_pkg::MODE_CRYSTAL_HIGH_SPEED);
  assign running = (state == ST_RUN) | (state == ST_SLEEP) | (state == ST_WAKE_START);
  // a trip counts once, on entry into brown-out hold
  assign brownout_event = brownout_trip & (state != ST_POR_WAIT) & (state != ST_HOLD);
  assign wake_any = i_wdt_timeout | i_wake_irq;
  assign wake_finish = ~brownout_event & ~pin_low &
    (((state == ST_SLEEP) & wake_any & ~crystal_mode) |
     ((state == ST_WAKE_START) & osc_edge & (count == OSC_LAST)));
  assign next_chip_reset = ~running | pin_low;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rc_prev <= 1'b0;
      osc_prev <= 1'b0;
      pin_low_prev <= 1'b0;
    end else begin
      rc_prev <= i_rc_osc_clk;
      osc_prev <= i_osc_input_pin;
      pin_low_prev <= pin_low;
    end
  end

  // ==========================================
  // brown-out qualification
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      qual_count <= '0;
      brownout_trip <= 1'b0;
    end else if (!brownout_active) begin
      qual_count <= '0;
      brownout_trip <= 1'b0;
    end else if (qual_count != QUAL_LAST) begin
      qual_count <= qual_count + QW'(1);
    end else begin
      brownout_trip <= 1'b1;
    end
  end

  // ==========================================
  // sequencing state machine
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state <= ST_POR_WAIT;
      count <= '0;
      power_up <= 1'b1;
    end else if (brownout_event) begin
      state <= ST_HOLD;
      count <= '0;
      power_up <= 1'b1;
    end else begin
      unique case (state)
        ST_POR_WAIT: begin
          // only a rising supply is watched here
          if (i_supply_above_por) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          count <= '0;
          if (!brownout_active && (power_up || !pin_low)) begin
            if (power_up && pud_enabled) begin
              state <= ST_PUD;
            end else if (power_up && crystal_mode) begin
              state <= ST_OSC_START;
            end else begin
              state <= ST_RUN;
            end
          end
        end
        ST_PUD: begin
          if (rc_edge) begin
            if (count == PUD_LAST) begin
              count <= '0;
              state <= crystal_mode ? ST_OSC_START : ST_RUN;
            end else begin
              count <= count + CW'(1);
            end
          end
        end
        ST_OSC_START: begin
          if (osc_edge) begin
            if (count == OSC_LAST) begin
              count <= '0;
              state <= ST_RUN;
              power_up <= 1'b0;
            end else begin
              count <= count + CW'(1);
            end
          end
        end
        ST_RUN: begin
          power_up <= 1'b0;
          if (pin_low || i_wdt_timeout) begin
            state <= ST_HOLD;
          end else if (i_sleep_cmd) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          count <= '0;
          if (pin_low) begin
            state <= ST_HOLD;
          end else if (wake_any) begin
            state <= crystal_mode ? ST_WAKE_START : ST_RUN;
          end
        end
        ST_WAKE_START: begin
          if (pin_low) begin
            state <= ST_HOLD;
          end else if (osc_edge) begin
            if (count == OSC_LAST) begin
              count <= '0;
              state <= ST_RUN;
            end else begin
              count <= count + CW'(1);
            end
          end
        end
      endcase
    end
  end

  // ==========================================
  // reset outputs and program counter
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_chip_reset <= 1'b1;
      o_pud_active <= 1'b0;
      o_osc_startup_active <= 1'b0;
    end else begin
      o_chip_reset <= next_chip_reset;
      o_pud_active <= (state == ST_PUD);
      o_osc_startup_active <= (state == ST_OSC_START) | (state == ST_WAKE_START);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wake_to_irq <= 1'b0;
    end else if ((state == ST_SLEEP) && wake_any) begin
      wake_to_irq <= i_wake_irq & i_global_irq_enable;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_pc_load <= 1'b0;
      o_pc_sel <= rts_pkg::PC_SEL_RESET;
      o_pc_vector <= rts_pkg::RESET_VECTOR;
    end else if (o_chip_reset && !next_chip_reset) begin
      o_pc_load <= 1'b1;
      o_pc_sel <= rts_pkg::PC_SEL_RESET;
      o_pc_vector <= rts_pkg::RESET_VECTOR;
    end else if (wake_finish) begin
      o_pc_load <= 1'b1;
      if ((state == ST_SLEEP) ? (i_wake_irq & i_global_irq_enable) : wake_to_irq) begin
        o_pc_sel <= rts_pkg::PC_SEL_IRQ;
        o_pc_vector <= rts_pkg::IRQ_VECTOR;
      end else begin
        o_pc_sel <= rts_pkg::PC_SEL_CONTINUE;
        o_pc_vector <= rts_pkg::RESET_VECTOR;
      end
    end else begin
      o_pc_load <= 1'b0;
    end
  end

  // ==========================================
  // time-out and power-down flags
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_timeout_flag <= 1'b1;
      o_power_down_flag <= 1'b1;
    end else if (brownout_event) begin
      o_timeout_flag <= 1'b1;
      o_power_down_flag <= 1'b1;
    end else if (state == ST_RUN && !pin_low && i_wdt_timeout) begin
      o_timeout_flag <= 1'b0;
    end else if (state == ST_SLEEP && !pin_low && i_wdt_timeout) begin
      o_timeout_flag <= 1'b0;
      o_power_down_flag <= 1'b0;
    end else if (state == ST_SLEEP && (pin_fall || i_wake_irq)) begin
      o_timeout_flag <= 1'b1;
      o_power_down_flag <= 1'b0;
    end else if (state == ST_RUN && i_sleep_cmd) begin
      o_timeout_flag <= 1'b1;
      o_power_down_flag <= 1'b0;
    end else if (state == ST_RUN && i_wdt_clear) begin
      o_timeout_flag <= 1'b1;
      o_power_down_flag <= 1'b1;
    end
  end

  // ==========================================
  // status upper and lower software bits
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      status_high <= rts_pkg::STATUS_HIGH_RST;
      status_low <= rts_pkg::STATUS_LOW_RST;
    end else if (brownout_event || (running && pin_fall) ||
                 (state == ST_RUN && i_wdt_timeout)) begin
      status_high <= rts_pkg::STATUS_HIGH_RST;
    end else if (i_wr && i_addr == rts_pkg::ADDR_PROCESSOR_STATUS) begin
      status_high <= i_wdata[7:5];
      status_low <= i_wdata[2:0];
    end
  end

  // ==========================================
  // reset-cause flags
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      power_on_flag <= 1'b0;
    end else if (i_wr && i_addr == rts_pkg::ADDR_RESET_CAUSE_FLAGS) begin
      power_on_flag <= i_wdata[rts_pkg::BIT_POWER_ON_FLAG];
    end
  end

  // a brown-out in the same cycle as a software write wins;
  // with detection off no event arrives and the flag is left to software
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      brownout_flag <= rts_pkg::BROWNOUT_FLAG_RST;
    end else if (brownout_event) begin
      brownout_flag <= 1'b0;
    end else if (i_wr && i_addr == rts_pkg::ADDR_RESET_CAUSE_FLAGS) begin
      brownout_flag <= i_wdata[rts_pkg::BIT_BROWNOUT_FLAG];
    end
  end

  // ==========================================
  // register read port
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_rd && i_addr == rts_pkg::ADDR_PROCESSOR_STATUS) begin
      o_rdata <= {status_high, o_timeout_flag, o_power_down_flag, status_low};
    end else if (i_rd && i_addr == rts_pkg::ADDR_RESET_CAUSE_FLAGS) begin
      o_rdata <= {6'h00, power_on_flag, brownout_flag};
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

// ===== design/rts_pkg.sv
// constants shared by the reset and time-out sequencer
// assumes a 125 MHz system clock and 8-bit register data
package rts_pkg;

  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PUD_TIME_MS = 72;
  // nominal period of the dedicated rc oscillator
  localparam int RC_OSC_PERIOD_US = 64;
  localparam int PUD_RC_TICKS = (PUD_TIME_MS * 1000 + RC_OSC_PERIOD_US - 1) / RC_OSC_PERIOD_US;
  localparam int OST_CYCLES = 1024;
  localparam int BROWNOUT_QUALIFY_NS = 100;
  localparam int BROWNOUT_QUALIFY_CYC =
    (BROWNOUT_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam int QUAL_W = 8;

  // ==========================================
  // register map
  localparam logic [7:0] ADDR_PROCESSOR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_RESET_CAUSE_FLAGS = 8'h8E;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_POWER_ON_FLAG = 1;
  localparam int BIT_BROWNOUT_FLAG = 0;
  localparam logic [2:0] STATUS_HIGH_RST = 3'h0;
  localparam logic [2:0] STATUS_LOW_RST = 3'h0;
  localparam logic BROWNOUT_FLAG_RST = 1'h0;

  // ==========================================
  // clock modes
  localparam logic [2:0] MODE_CRYSTAL_LOW_POWER = 3'h0;
  localparam logic [2:0] MODE_CRYSTAL_MID = 3'h1;
  localparam logic [2:0] MODE_CRYSTAL_HIGH_SPEED = 3'h2;
  localparam logic [2:0] MODE_EXTERNAL_CLOCK = 3'h3;
  localparam logic [2:0] MODE_RC = 3'h4;
  localparam logic [2:0] MODE_INTERNAL_OSC = 3'h5;

  // ==========================================
  // program counter actions
  localparam logic [1:0] PC_SEL_RESET = 2'h0;
  localparam logic [1:0] PC_SEL_CONTINUE = 2'h1;
  localparam logic [1:0] PC_SEL_IRQ = 2'h2;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

endpackage

// ===== dv/rts_partner.sv
// far side model: supply monitors and the two oscillators
// assumes the bench steers supply levels through i_powered and i_supply_low
`timescale 1ns/10ps
module rts_partner (
  input wire logic i_clock,
  input wire logic i_powered,
  input wire logic i_supply_low,
  output logic o_supply_above_por,
  output logic o_supply_below_brownout,
  output logic o_rc_osc_clk,
  output logic o_osc_input_pin
);
  logic [1:0] rc_div = 2'h0;
  logic osc = 1'b0;
  // rc period 4 cycles, oscillator input period 2 cycles, both free running
  always_ff @(posedge i_clock) begin
    rc_div <= rc_div + 2'h1;
    osc <= ~osc;
  end
  assign o_rc_osc_clk = rc_div[1];
  assign o_osc_input_pin = osc;
  assign o_supply_above_por = i_powered;
  assign o_supply_below_brownout = i_supply_low;
endmodule

// ===== dv/rts_sequencer_checker.sv
// assertions on the ports of rts_sequencer
// assumes one clock domain and the synchronous reset i_srst
`timescale 1ns/10ps
module rts_checker #(
  parameter int BROWNOUT_QUAL_CYC = rts_pkg::BROWNOUT_QUALIFY_CYC
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_supply_below_brownout,
  input wire logic i_brownout_enable_cfg,
  input wire logic i_external_reset_pin_n,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_chip_reset,
  input wire logic o_pud_active,
  input wire logic o_pc_load,
  input wire logic [1:0] o_pc_sel,
  input wire logic [12:0] o_pc_vector,
  input wire logic o_timeout_flag,
  input wire logic o_power_down_flag
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic [7:0] low_run;
  // consecutive cycles of qualified low supply
  always_ff @(posedge i_clock) begin
    if (i_srst || !(i_supply_below_brownout && i_brownout_enable_cfg)) begin
      low_run <= 8'h00;
    end else if (low_run != 8'hFF) begin
      low_run <= low_run + 8'h01;
    end
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) != 8'h03 &&
    $past(i_addr) != 8'h8E |-> o_rdata == 8'h00) else $error("unmapped read not zero");
  a_flags_upper: assert property ($past(i_rd) && $past(i_addr) == 8'h8E
    |-> o_rdata[7:2] == 6'h00) else $error("flag register upper bits set");
  a_status_flags: assert property ($past(i_rd) && $past(i_addr) == 8'h03 |->
    o_rdata[4:3] == {$past(o_timeout_flag), $past(o_power_down_flag)})
    else $error("status flag bits differ from flags");
  a_pin_reset: assert property (!i_external_reset_pin_n |=> o_chip_reset)
    else $error("pin low without chip reset");
  a_release_vec: assert property ($fell(o_chip_reset) |-> o_pc_load &&
    o_pc_sel == rts_pkg::PC_SEL_RESET && o_pc_vector == 13'h0000)
    else $error("release without reset vector load");
  a_load_pulse: assert property (o_pc_load |=> !o_pc_load)
    else $error("pc load longer than one cycle");
  a_irq_vector: assert property (o_pc_load && o_pc_sel == rts_pkg::PC_SEL_IRQ
    |-> o_pc_vector == 13'h0004) else $error("irq vector wrong");
  a_delay_holds: assert property (o_pud_active |-> o_chip_reset)
    else $error("delay active without chip reset");
  a_por_flags: assert property ($past(i_srst) |-> o_timeout_flag &&
    o_power_down_flag) else $error("power-on flags wrong");
  a_brownout_trip: assert property (low_run > BROWNOUT_QUAL_CYC + 1
    |-> ##[0:3] o_chip_reset) else $error("brown-out did not reset");
  c_delay: cover property ($rose(o_pud_active));
  c_irq: cover property (o_pc_load && o_pc_sel == rts_pkg::PC_SEL_IRQ);
  c_trip: cover property (low_run > BROWNOUT_QUAL_CYC + 1 && o_chip_reset);
endmodule
bind rts_sequencer rts_checker #(.BROWNOUT_QUAL_CYC(BROWNOUT_QUAL_CYC)) i_rts_checker (
  .i_clock, .i_srst, .i_supply_below_brownout, .i_brownout_enable_cfg,
  .i_external_reset_pin_n, .i_addr, .i_rd, .o_rdata, .o_chip_reset, .o_pud_active,
  .o_pc_load, .o_pc_sel, .o_pc_vector, .o_timeout_flag, .o_power_down_flag);

// ===== dv/test_reset_timeout_sequencer.sv
// self-checking bench for rts_sequencer with the partner model
// assumes shortened counts: delay 4 rc ticks, 4 oscillator edges, qualify 2
`timescale 1ns/10ps
module test_reset_timeout_sequencer;
  // fewest cycles from leaving hold to release: 4 rc edges span 12, 4 osc edges 6
  localparam int MIN_DLY = 3 * 4 + 3 * 2 + 2;
  logic i_clock = 1'b0;
  logic srst = 1'b1, powered = 1'b0, low = 1'b0, pin_n = 1'b1;
  logic pud_dis = 1'b0, bo_en = 1'b1, global_irq_enable = 1'b0;
  logic wdt = 1'b0, wclr = 1'b0, slp = 1'b0, wake = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [2:0] mode = rts_pkg::MODE_CRYSTAL_MID;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic above, below, rc, osc, crst, pud, osc_startup_counter, load, to_f, pd_f, saw_pud, saw_ost;
  logic [1:0] sel;
  logic [12:0] vec;
  int miscompares = 0, n_compared = 0, n;
  initial forever #4 i_clock = ~i_clock;
  rts_partner i_rts_partner (.i_clock(i_clock), .i_powered(powered), .i_supply_low(low),
    .o_supply_above_por(above), .o_supply_below_brownout(below), .o_rc_osc_clk(rc),
    .o_osc_input_pin(osc));
  rts_sequencer #(.PUD_TICKS(4), .OSC_STARTUP_EDGES(4), .BROWNOUT_QUAL_CYC(2)) i_rts_sequencer (
    .i_clock(i_clock), .i_srst(srst), .i_supply_above_por(above),
    .i_supply_below_brownout(below), .i_rc_osc_clk(rc), .i_osc_input_pin(osc),
    .i_external_reset_pin_n(pin_n), .i_power_up_delay_disable_cfg(pud_dis),
    .i_brownout_enable_cfg(bo_en), .i_clock_mode(mode), .i_wdt_timeout(wdt),
    .i_wdt_clear(wclr), .i_sleep_cmd(slp), .i_wake_irq(wake), .i_global_irq_enable(global_irq_enable),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_chip_reset(crst), .o_pud_active(pud), .o_osc_startup_active(osc_startup_counter), .o_pc_load(load),
    .o_pc_sel(sel), .o_pc_vector(vec), .o_timeout_flag(to_f), .o_power_down_flag(pd_f));
  always @(posedge i_clock) begin
    saw_pud <= saw_pud | pud;
    saw_ost <= saw_ost | osc_startup_counter;
  end
  // ==========================================
  // tasks
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1;
    chk_byte(rdata, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge i_clock);
    case (k)
      0: wdt <= 1'b1;
      1: wclr <= 1'b1;
      2: slp <= 1'b1;
      3: wake <= 1'b1;
      default: srst <= 1'b1;
    endcase
    @(posedge i_clock);
    {wdt, wclr, slp, wake, srst} <= 5'h00;
  endtask
  // counts cycles until chip reset falls, clearing the seen-flags first
  task automatic wait_rel(output int c);
    c = 0;
    saw_pud = 1'b0;
    saw_ost = 1'b0;
    while (crst !== 1'b0 && c < 3000) begin
      @(posedge i_clock);
      #1;
      c++;
    end
  endtask
  task automatic wait_load();
    #1;
    for (int i = 0; i < 200 && load !== 1'b1; i++) begin
      @(posedge i_clock);
      #1;
    end
  endtask
  task automatic set_low(input logic v, input int cyc);
    @(posedge i_clock);
    low <= v;
    repeat (cyc) @(posedge i_clock);
    #1;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #160000;
    miscompares++;
    print_verdict();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (5) @(posedge i_clock);
    srst <= 1'b0;
    powered <= 1'b1;
    #1;
    wait_rel(n);
    chk_bit(n >= MIN_DLY && n <= MIN_DLY + 12, 1'b1);
    chk_byte({6'h0, saw_pud, saw_ost}, 8'h03);
    rd_reg(8'h03, 8'h18);
    rd_reg(8'h8E, 8'h00);
    wr_reg(8'h8E, 8'hFF);
    rd_reg(8'h8E, 8'h03);
    wr_reg(8'h03, 8'h00);
    rd_reg(8'h03, 8'h18);
    wr_reg(8'h03, 8'hFF);
    wr_reg(8'h40, 8'h55);
    rd_reg(8'h40, 8'h00);
    set_low(1'b1, 8);
    chk_bit(crst, 1'b1);
    set_low(1'b0, 0);
    for (int i = 0; i < 200 && pud !== 1'b1; i++) set_low(1'b0, 0);
    set_low(1'b1, 6);
    set_low(1'b0, 0);
    wait_rel(n);
    chk_bit(n >= MIN_DLY && n <= MIN_DLY + 12 && saw_ost, 1'b1);
    rd_reg(8'h8E, 8'h02);
    rd_reg(8'h03, 8'h1F);
    @(posedge i_clock);
    bo_en <= 1'b0;
    set_low(1'b1, 20);
    chk_bit(crst, 1'b0);
    set_low(1'b0, 1);
    @(posedge i_clock);
    bo_en <= 1'b1;
    pulse(0);
    @(posedge i_clock);
    #1;
    chk_bit(crst, 1'b1);
    wait_rel(n);
    chk_byte({5'h0, to_f, pd_f, n <= 4}, 8'h03);
    pulse(2);
    pulse(0);
    wait_load();
    chk_byte({4'h0, sel, to_f, pd_f}, 8'h04);
    chk_byte({load, vec[6:0]}, 8'h80);
    chk_bit(saw_ost, 1'b1);
    pulse(1);
    #1;
    chk_byte({6'h0, to_f, pd_f}, 8'h03);
    @(posedge i_clock);
    mode <= rts_pkg::MODE_CRYSTAL_HIGH_SPEED;
    pulse(2);
    #1;
    saw_ost = 1'b0;
    pulse(0);
    wait_load();
    chk_bit(load & saw_ost, 1'b1);
    @(posedge i_clock);
    mode <= rts_pkg::MODE_RC;
    global_irq_enable <= 1'b1;
    pulse(2);
    #1;
    saw_ost = 1'b0;
    pulse(3);
    wait_load();
    chk_byte({4'h0, sel, to_f, pd_f}, 8'h0A);
    chk_byte({load, vec[6:0]}, 8'h84);
    chk_bit(saw_ost, 1'b0);
    @(posedge i_clock);
    pin_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    pin_n <= 1'b1;
    #1;
    wait_rel(n);
    chk_byte({5'h0, to_f, pd_f, n <= 2}, 8'h05);
    @(posedge i_clock);
    mode <= rts_pkg::MODE_CRYSTAL_LOW_POWER;
    pin_n <= 1'b0;
    pulse(4);
    repeat (MIN_DLY + 20) @(posedge i_clock);
    pin_n <= 1'b1;
    #1;
    wait_rel(n);
    chk_bit(n <= 2, 1'b1);
    @(posedge i_clock);
    mode <= rts_pkg::MODE_EXTERNAL_CLOCK;
    pud_dis <= 1'b1;
    pulse(4);
    #1;
    wait_rel(n);
    chk_byte({6'h0, n <= 4, saw_pud}, 8'h02);
    @(posedge i_clock);
    mode <= rts_pkg::MODE_INTERNAL_OSC;
    set_low(1'b1, 8);
    set_low(1'b0, 0);
    wait_rel(n);
    chk_byte({6'h0, n <= 4, saw_pud}, 8'h02);
    print_verdict();
  end
endmodule
